// [hw/mrb_msr_slice.sv]
`timescale 1ns/1ps
module mrb_msr_slice
	import mrb_pkg::*;
#(
	parameter logic [63:0] MC_CAP_VALUE = 64'h0000000000000000,
	parameter logic [63:0] MTYPE_CAP_VALUE = 64'h0000000000000000
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire mrb_req_t req,
	output mrb_rsp_t rsp,
	input wire logic identify_leaf1,
	input wire logic [31:0] update_signature,
	input wire logic update_loaded,
	input wire logic vm_transition,
	input wire logic feature_monitor,
	input wire logic capability_monitor,
	input wire logic system_management_mode,
	input wire mrb_mc_event_t mc_event,
	output logic [63:0] fast_call_code_selector_q,
	output logic [63:0] fast_call_stack_pointer_q,
	output logic [63:0] fast_call_entry_pointer_q,
	output logic machine_check_enabled
);

	// register state
	logic [63:0] microcode_signature, next_microcode_signature;
	logic [63:0] smm_monitor_config, next_smm_monitor_config;
	logic [63:0] code_sel, next_code_sel;
	logic [63:0] stack_ptr, next_stack_ptr;
	logic [63:0] entry_ptr, next_entry_ptr;
	logic [63:0] mc_status, next_mc_status;
	logic [63:0] mc_enable, next_mc_enable;
	logic [63:0] acc_save, next_acc_save;
	mrb_rsp_t next_rsp;
	logic monitor_present;
	logic wr_hit;
	logic next_machine_check_enabled;

	// true when the request writes the given register
	function automatic logic wr_to(input mrb_req_t r, input logic [11:0] idx);
		return r.wr && (r.idx == idx);
	endfunction

	assign monitor_present = feature_monitor && capability_monitor;
	assign wr_hit = req.wr;

	// next-state for the registers
	always_comb begin
		next_microcode_signature = microcode_signature;
		next_smm_monitor_config = smm_monitor_config;
		next_code_sel = code_sel;
		next_stack_ptr = stack_ptr;
		next_entry_ptr = entry_ptr;
		next_mc_status = mc_status;
		next_mc_enable = mc_enable;
		next_acc_save = acc_save;
		// software write, blocked during vm transitions, low half ignored
		if (wr_to(req, IDX_MICROCODE_SIGNATURE) && !vm_transition) begin
			next_microcode_signature = req.wdata & SIG_FIELD_MASK;
		end
		// identify instruction loads the signature, or zero without update
		if (identify_leaf1) begin
			next_microcode_signature = update_loaded ?
				{update_signature, {SIG_LSB{1'b0}}} : RESET_VALUE;
		end
		if (wr_to(req, IDX_SMM_MONITOR_CONFIG) && monitor_present
				&& system_management_mode) begin
			next_smm_monitor_config = req.wdata;
		end
		if (wr_to(req, IDX_FAST_CALL_CODE_SELECTOR)) begin
			next_code_sel = req.wdata;
		end
		if (wr_to(req, IDX_FAST_CALL_STACK_POINTER)) begin
			next_stack_ptr = req.wdata;
		end
		if (wr_to(req, IDX_FAST_CALL_ENTRY_POINTER)) begin
			next_entry_ptr = req.wdata;
		end
		if (wr_to(req, IDX_MACHINE_CHECK_GLOBAL_ENABLE)) begin
			next_mc_enable = req.wdata;
		end
		// machine-check capture of status and accumulator
		if (mc_event.raise) begin
			next_mc_status = mc_event.status;
			next_acc_save = mc_event.long_mode ? mc_event.accumulator :
				(mc_event.accumulator & LOW_HALF_MASK);
		end
		// enable output follows any set enable bit, kept in a flop
		next_machine_check_enabled = |next_mc_enable;
	end

	// read mux and access answer
	always_comb begin
		next_rsp = '0;
		next_rsp.ack = req.rd || req.wr;
		if (req.rd) begin
			case (req.idx)
				IDX_MICROCODE_SIGNATURE: next_rsp.rdata = microcode_signature;
				IDX_SMM_MONITOR_CONFIG: begin
					next_rsp.rdata = smm_monitor_config;
					next_rsp.fault = !monitor_present;
				end
				IDX_MEMORY_TYPE_CAPABILITY: next_rsp.rdata = MTYPE_CAP_VALUE;
				IDX_FAST_CALL_CODE_SELECTOR: next_rsp.rdata = code_sel;
				IDX_FAST_CALL_STACK_POINTER: next_rsp.rdata = stack_ptr;
				IDX_FAST_CALL_ENTRY_POINTER: next_rsp.rdata = entry_ptr;
				IDX_MACHINE_CHECK_CAPABILITY: next_rsp.rdata = MC_CAP_VALUE;
				IDX_MACHINE_CHECK_GLOBAL_STATUS: next_rsp.rdata = mc_status;
				IDX_MACHINE_CHECK_GLOBAL_ENABLE: next_rsp.rdata = mc_enable;
				IDX_MACHINE_CHECK_ACCUMULATOR_SAVE: next_rsp.rdata = acc_save;
				default: next_rsp.fault = 1'b1;
			endcase
		end else if (wr_hit) begin
			case (req.idx)
				IDX_MICROCODE_SIGNATURE,
				IDX_FAST_CALL_CODE_SELECTOR,
				IDX_FAST_CALL_STACK_POINTER,
				IDX_FAST_CALL_ENTRY_POINTER,
				IDX_MACHINE_CHECK_GLOBAL_ENABLE: next_rsp.fault = 1'b0;
				IDX_SMM_MONITOR_CONFIG: next_rsp.fault = !monitor_present ||
					!system_management_mode;
				default: next_rsp.fault = 1'b1;
			endcase
		end
	end

	// registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			microcode_signature <= RESET_VALUE;
			smm_monitor_config <= RESET_VALUE;
			code_sel <= RESET_VALUE;
			stack_ptr <= RESET_VALUE;
			entry_ptr <= RESET_VALUE;
			mc_status <= RESET_VALUE;
			mc_enable <= RESET_VALUE;
			acc_save <= RESET_VALUE;
			rsp <= '0;
			machine_check_enabled <= 1'b0;
		end else begin
			microcode_signature <= next_microcode_signature;
			smm_monitor_config <= next_smm_monitor_config;
			code_sel <= next_code_sel;
			stack_ptr <= next_stack_ptr;
			entry_ptr <= next_entry_ptr;
			mc_status <= next_mc_status;
			mc_enable <= next_mc_enable;
			acc_save <= next_acc_save;
			rsp <= next_rsp;
			machine_check_enabled <= next_machine_check_enabled;
		end
	end

	assign fast_call_code_selector_q = code_sel;
	assign fast_call_stack_pointer_q = stack_ptr;
	assign fast_call_entry_pointer_q = entry_ptr;

	// identify with an update loaded puts the signature in the upper half
	a_sig_loaded: assert property (@(posedge clk_sys) disable iff (rst)
		identify_leaf1 && update_loaded
		|=> microcode_signature == {$past(update_signature), {SIG_LSB{1'b0}}})
		else $error("signature not loaded after identify");

	// identify without an update leaves the field at zero
	a_sig_zero: assert property (@(posedge clk_sys) disable iff (rst)
		identify_leaf1 && !update_loaded
		|=> microcode_signature == RESET_VALUE)
		else $error("signature not zero without update");

	// software writes are dropped while guest state moves
	a_sig_block: assert property (@(posedge clk_sys) disable iff (rst)
		wr_to(req, IDX_MICROCODE_SIGNATURE) && vm_transition && !identify_leaf1
		|=> $stable(microcode_signature))
		else $error("signature written during vm transition");

	// an accepted software write keeps only the signature field
	a_sig_write: assert property (@(posedge clk_sys) disable iff (rst)
		wr_to(req, IDX_MICROCODE_SIGNATURE) && !vm_transition && !identify_leaf1
		|=> microcode_signature == ($past(req.wdata) & SIG_FIELD_MASK))
		else $error("signature write not masked");

	// the reserved low half never holds a one
	a_sig_resv: assert property (@(posedge clk_sys) disable iff (rst)
		(microcode_signature & LOW_HALF_MASK) == RESET_VALUE)
		else $error("reserved signature bits set");

	// a read of the signature shows zero in the reserved half
	a_sig_rd_resv: assert property (@(posedge clk_sys) disable iff (rst)
		req.rd && req.idx == IDX_MICROCODE_SIGNATURE
		|=> rsp.ack && (rsp.rdata & LOW_HALF_MASK) == RESET_VALUE)
		else $error("reserved signature bits read back");

	// monitor config holds unless present and in system management mode
	a_mon_guard: assert property (@(posedge clk_sys) disable iff (rst)
		!(monitor_present && system_management_mode)
		|=> $stable(smm_monitor_config))
		else $error("monitor config written outside system management mode");

	// a permitted write lands in the monitor config
	a_mon_write: assert property (@(posedge clk_sys) disable iff (rst)
		wr_to(req, IDX_SMM_MONITOR_CONFIG) && monitor_present && system_management_mode
		|=> smm_monitor_config == $past(req.wdata))
		else $error("monitor config write lost");

	// reading an absent monitor config faults
	a_mon_absent: assert property (@(posedge clk_sys) disable iff (rst)
		req.rd && req.idx == IDX_SMM_MONITOR_CONFIG && !monitor_present
		|=> rsp.ack && rsp.fault)
		else $error("absent monitor config read without fault");

	// a refused monitor config write faults
	a_mon_deny: assert property (@(posedge clk_sys) disable iff (rst)
		wr_to(req, IDX_SMM_MONITOR_CONFIG) && !(monitor_present && system_management_mode)
		|=> rsp.ack && rsp.fault)
		else $error("refused monitor config write without fault");

	// a written selector reads back after one idle cycle
	a_sel_write: assert property (@(posedge clk_sys) disable iff (rst)
		wr_to(req, IDX_FAST_CALL_CODE_SELECTOR) ##1 !req.wr
		##1 (req.rd && req.idx == IDX_FAST_CALL_CODE_SELECTOR)
		|=> rsp.rdata == $past(req.wdata, 3))
		else $error("code selector readback wrong");

	// the selector changes only on its own write
	a_sel_keep: assert property (@(posedge clk_sys) disable iff (rst)
		!wr_to(req, IDX_FAST_CALL_CODE_SELECTOR) |=> $stable(code_sel))
		else $error("code selector changed without write");

	// a stack pointer write lands the next cycle
	a_stack_write: assert property (@(posedge clk_sys) disable iff (rst)
		wr_to(req, IDX_FAST_CALL_STACK_POINTER)
		|=> stack_ptr == $past(req.wdata))
		else $error("stack pointer not written");

	// the stack pointer changes only on its own write
	a_stack_keep: assert property (@(posedge clk_sys) disable iff (rst)
		!wr_to(req, IDX_FAST_CALL_STACK_POINTER) |=> $stable(stack_ptr))
		else $error("stack pointer changed without write");

	// an entry pointer write lands the next cycle
	a_entry_write: assert property (@(posedge clk_sys) disable iff (rst)
		wr_to(req, IDX_FAST_CALL_ENTRY_POINTER)
		|=> entry_ptr == $past(req.wdata))
		else $error("entry pointer not written");

	// the entry pointer changes only on its own write
	a_entry_keep: assert property (@(posedge clk_sys) disable iff (rst)
		!wr_to(req, IDX_FAST_CALL_ENTRY_POINTER) |=> $stable(entry_ptr))
		else $error("entry pointer changed without write");

	// machine-check capability reads return the fixed value
	a_cap_ro: assert property (@(posedge clk_sys) disable iff (rst)
		req.rd && req.idx == IDX_MACHINE_CHECK_CAPABILITY
		|=> rsp.ack && rsp.rdata == MC_CAP_VALUE)
		else $error("capability readback wrong");

	// writes to the capability registers fault
	a_cap_write: assert property (@(posedge clk_sys) disable iff (rst)
		req.wr && (req.idx == IDX_MACHINE_CHECK_CAPABILITY
		|| req.idx == IDX_MEMORY_TYPE_CAPABILITY) |=> rsp.ack && rsp.fault)
		else $error("capability write accepted");

	// a machine-check event captures the status word
	a_status_cap: assert property (@(posedge clk_sys) disable iff (rst)
		mc_event.raise
		|=> mc_status == $past(mc_event.status))
		else $error("status not captured");

	// software cannot write the status register
	a_status_ro: assert property (@(posedge clk_sys) disable iff (rst)
		req.wr && req.idx == IDX_MACHINE_CHECK_GLOBAL_STATUS && !mc_event.raise
		|=> $stable(mc_status))
		else $error("status changed by write");

	// the enable output follows the written enable bits
	a_enable_out: assert property (@(posedge clk_sys) disable iff (rst)
		wr_to(req, IDX_MACHINE_CHECK_GLOBAL_ENABLE)
		|=> machine_check_enabled == (|$past(req.wdata)))
		else $error("enable not applied");

	// the enable register changes only on its own write
	a_enable_keep: assert property (@(posedge clk_sys) disable iff (rst)
		!wr_to(req, IDX_MACHINE_CHECK_GLOBAL_ENABLE) |=> $stable(mc_enable))
		else $error("enable changed without write");

	// in long mode the whole accumulator is saved
	a_acc_long: assert property (@(posedge clk_sys) disable iff (rst)
		mc_event.raise && mc_event.long_mode
		|=> acc_save == $past(mc_event.accumulator))
		else $error("accumulator not saved");

	// software cannot write the save-state register
	a_acc_ro: assert property (@(posedge clk_sys) disable iff (rst)
		req.wr && req.idx == IDX_MACHINE_CHECK_ACCUMULATOR_SAVE && !mc_event.raise
		|=> $stable(acc_save))
		else $error("save state changed by write");

	// outside long mode only the low half is kept
	a_acc_short: assert property (@(posedge clk_sys) disable iff (rst)
		mc_event.raise && !mc_event.long_mode
		|=> acc_save == ($past(mc_event.accumulator) & LOW_HALF_MASK))
		else $error("upper half kept outside long mode");
endmodule

// [hw/mrb_pkg.sv]
package mrb_pkg;
	// register indices (model register numbers)
	localparam logic [11:0] IDX_MICROCODE_SIGNATURE = 12'h08b;
	localparam logic [11:0] IDX_SMM_MONITOR_CONFIG = 12'h09b;
	localparam logic [11:0] IDX_MEMORY_TYPE_CAPABILITY = 12'h0fe;
	localparam logic [11:0] IDX_FAST_CALL_CODE_SELECTOR = 12'h174;
	localparam logic [11:0] IDX_FAST_CALL_STACK_POINTER = 12'h175;
	localparam logic [11:0] IDX_FAST_CALL_ENTRY_POINTER = 12'h176;
	localparam logic [11:0] IDX_MACHINE_CHECK_CAPABILITY = 12'h179;
	localparam logic [11:0] IDX_MACHINE_CHECK_GLOBAL_STATUS = 12'h17a;
	localparam logic [11:0] IDX_MACHINE_CHECK_GLOBAL_ENABLE = 12'h17b;
	localparam logic [11:0] IDX_MACHINE_CHECK_ACCUMULATOR_SAVE = 12'h180;
	// field layout of the signature register, reset value and monitor feature bit positions
	localparam int SIG_LSB = 32;
	localparam int SIG_W = 32;
	localparam logic [63:0] SIG_FIELD_MASK = 64'hffffffff_00000000;
	localparam logic [63:0] LOW_HALF_MASK = 64'h00000000_ffffffff;
	localparam logic [63:0] RESET_VALUE = 64'h0;
	localparam int FEAT_MONITOR_BIT = 9;
	localparam int CAP_MONITOR_BIT = 49;

	// register access request from the core
	typedef struct packed {
		logic rd;
		logic wr;
		logic [11:0] idx;
		logic [63:0] wdata;
	} mrb_req_t;

	// answer to the core
	typedef struct packed {
		logic ack;
		logic fault;
		logic [63:0] rdata;
	} mrb_rsp_t;

	// machine-check capture event with the accumulator value
	typedef struct packed {
		logic raise;
		logic long_mode;
		logic [63:0] status;
		logic [63:0] accumulator;
	} mrb_mc_event_t;
endpackage

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
	import mrb_pkg::*;
	localparam logic [63:0] MC_CAP = 64'h0000000000000c0a; // arbitrary
	localparam logic [63:0] MT_CAP = 64'h0000000000000508; // arbitrary
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic identify_leaf1 = 1'b0;
	logic update_loaded = 1'b0;
	logic vm_transition = 1'b0;
	logic feature_monitor = 1'b0;
	logic capability_monitor = 1'b0;
	logic system_management_mode = 1'b0;
	logic [31:0] update_signature = 32'h0;
	mrb_req_t req = '0;
	mrb_rsp_t rsp;
	mrb_mc_event_t mc_event = '0;
	logic [63:0] cs_q, sp_q, ip_q;
	logic mc_en;
	int n_fail = 0;
	int tests_run = 0;
	logic [11:0] rw_idx [3] = '{IDX_FAST_CALL_CODE_SELECTOR, IDX_FAST_CALL_STACK_POINTER,
		IDX_FAST_CALL_ENTRY_POINTER};
	logic [11:0] ro_idx [4] = '{IDX_MEMORY_TYPE_CAPABILITY, IDX_MACHINE_CHECK_CAPABILITY,
		IDX_MACHINE_CHECK_GLOBAL_STATUS, IDX_MACHINE_CHECK_ACCUMULATOR_SAVE};

	mrb_msr_slice #(.MC_CAP_VALUE(MC_CAP), .MTYPE_CAP_VALUE(MT_CAP)) mrb_msr_slice_i (
		.clk_sys(clk_sys), .rst(rst), .req(req), .rsp(rsp), .identify_leaf1(identify_leaf1),
		.update_signature(update_signature), .update_loaded(update_loaded),
		.vm_transition(vm_transition), .feature_monitor(feature_monitor),
		.capability_monitor(capability_monitor), .system_management_mode(system_management_mode),
		.mc_event(mc_event), .fast_call_code_selector_q(cs_q), .fast_call_stack_pointer_q(sp_q),
		.fast_call_entry_pointer_q(ip_q), .machine_check_enabled(mc_en));

	// free running system clock
	initial begin
		forever #50 clk_sys = ~clk_sys;
	end

	// compare of 64-bit values
	task automatic chk_val(input string m, input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// compare of single flags
	task automatic chk_bit(input string m, input logic got, input logic exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t %s got %b exp %b", $time, m, got, exp);
		end
	endtask

	// one access: request for one cycle, answer checked in the following cycle
	task automatic acc(input logic w, input logic [11:0] i, input logic [63:0] d,
		input logic f, input logic [63:0] e);
		@(posedge clk_sys);
		#1 req = '{~w, w, i, d};
		@(posedge clk_sys);
		#1 req = '0;
		chk_bit("ack", rsp.ack, 1'b1);
		chk_bit("fault", rsp.fault, f);
		if (!w) chk_val("rdata", rsp.rdata, e);
	endtask

	// identify instruction leaf one, one cycle
	task automatic identify;
		@(posedge clk_sys);
		#1 identify_leaf1 = 1'b1;
		@(posedge clk_sys);
		#1 identify_leaf1 = 1'b0;
	endtask

	// machine-check capture event, one cycle
	task automatic mc(input logic lm, input logic [63:0] s, input logic [63:0] a);
		@(posedge clk_sys);
		#1 mc_event = '{1'b1, lm, s, a};
		@(posedge clk_sys);
		#1 mc_event.raise = 1'b0;
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// watchdog: the sequence needs about a hundred cycles
	initial begin
		#400000;
		n_fail++;
		report_and_stop();
	end

	initial begin
		repeat (6) @(posedge clk_sys);
		#1 rst = 1'b0;
		for (int k = 0; k < 3; k++) begin
			acc(0, rw_idx[k], 0, 0, 64'h0);
			acc(1, rw_idx[k], 64'hfedcba9876543210 + 64'(k), 0, 0);
			acc(0, rw_idx[k], 0, 0, 64'hfedcba9876543210 + 64'(k));
		end
		chk_val("sel", cs_q, 64'hfedcba9876543210);
		chk_val("stack", sp_q, 64'hfedcba9876543211);
		chk_val("entry", ip_q, 64'hfedcba9876543212);
		for (int k = 0; k < 4; k++) acc(1, ro_idx[k], '1, 1, 0);
		acc(0, IDX_MACHINE_CHECK_CAPABILITY, 0, 0, MC_CAP);
		acc(0, IDX_MEMORY_TYPE_CAPABILITY, 0, 0, MT_CAP);
		acc(0, 12'h17c, 0, 1, 64'h0);
		acc(1, IDX_MACHINE_CHECK_GLOBAL_ENABLE, 64'h1, 0, 0);
		chk_bit("mc enable", mc_en, 1'b1);
		acc(0, IDX_MACHINE_CHECK_GLOBAL_ENABLE, 0, 0, 64'h1);
		acc(1, IDX_MACHINE_CHECK_GLOBAL_ENABLE, 64'h0, 0, 0);
		chk_bit("mc disable", mc_en, 1'b0);
		identify();
		acc(0, IDX_MICROCODE_SIGNATURE, 0, 0, 64'h0);
		update_loaded = 1'b1;
		update_signature = 32'h1234abcd;
		identify();
		acc(0, IDX_MICROCODE_SIGNATURE, 0, 0, 64'h1234abcd_00000000);
		acc(1, IDX_MICROCODE_SIGNATURE, 64'h0, 0, 0);
		acc(0, IDX_MICROCODE_SIGNATURE, 0, 0, 64'h0);
		acc(1, IDX_MICROCODE_SIGNATURE, 64'h5a5a0f0f_ffffffff, 0, 0);
		acc(0, IDX_MICROCODE_SIGNATURE, 0, 0, 64'h5a5a0f0f_00000000);
		vm_transition = 1'b1;
		acc(1, IDX_MICROCODE_SIGNATURE, 64'h11110000_00000000, 0, 0);
		vm_transition = 1'b0;
		acc(0, IDX_MICROCODE_SIGNATURE, 0, 0, 64'h5a5a0f0f_00000000);
		// identify and a signature write in one cycle: identify wins
		fork
			identify();
			acc(1, IDX_MICROCODE_SIGNATURE, 64'h77770000_00000000, 0, 0);
		join
		acc(0, IDX_MICROCODE_SIGNATURE, 0, 0, 64'h1234abcd_00000000);
		acc(0, IDX_SMM_MONITOR_CONFIG, 0, 1, 64'h0);
		feature_monitor = 1'b1;
		acc(0, IDX_SMM_MONITOR_CONFIG, 0, 1, 64'h0);
		capability_monitor = 1'b1;
		acc(1, IDX_SMM_MONITOR_CONFIG, 64'h1, 1, 0);
		acc(0, IDX_SMM_MONITOR_CONFIG, 0, 0, 64'h0);
		system_management_mode = 1'b1;
		acc(1, IDX_SMM_MONITOR_CONFIG, 64'h1, 0, 0);
		acc(0, IDX_SMM_MONITOR_CONFIG, 0, 0, 64'h1);
		mc(1'b1, 64'h5, 64'h87654321_0fedcba9);
		acc(0, IDX_MACHINE_CHECK_GLOBAL_STATUS, 0, 0, 64'h5);
		acc(0, IDX_MACHINE_CHECK_ACCUMULATOR_SAVE, 0, 0, 64'h87654321_0fedcba9);
		mc(1'b0, 64'h4, 64'hffffffff_13579bdf);
		acc(0, IDX_MACHINE_CHECK_GLOBAL_STATUS, 0, 0, 64'h4);
		acc(0, IDX_MACHINE_CHECK_ACCUMULATOR_SAVE, 0, 0, 64'h13579bdf);
		acc(1, IDX_MACHINE_CHECK_GLOBAL_ENABLE, 64'h1, 0, 0);
		// mid-run reset clears every register
		rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 rst = 1'b0;
		chk_val("sel rst", cs_q, 64'h0);
		chk_val("stack rst", sp_q, 64'h0);
		chk_val("entry rst", ip_q, 64'h0);
		chk_bit("enable rst", mc_en, 1'b0);
		acc(0, IDX_MACHINE_CHECK_GLOBAL_STATUS, 0, 0, 64'h0);
		acc(0, IDX_MACHINE_CHECK_ACCUMULATOR_SAVE, 0, 0, 64'h0);
		acc(0, IDX_MICROCODE_SIGNATURE, 0, 0, 64'h0);
		report_and_stop();
	end
endmodule
